// File: rie_regs.svh
/*
  Register map, field positions, reset values and bus codes of the
  interrupt-enable block of the real-time counter.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef RIE_REGS_SVH
`define RIE_REGS_SVH

// register indices; byte address is four times the index
`define RIE_IDX_ENCLR 6'h06
`define RIE_IDX_ENSET 6'h07
`define RIE_IDX_FLAGS 6'h08
`define RIE_IDX_MODE 6'h0C

// field positions
`define RIE_BIT_OVF 7
`define RIE_BIT_SYNC 6
`define RIE_BIT_COMPARE1_SOURCE 1
`define RIE_BIT_COMPARE0_SOURCE 0

// reset values
`define RIE_EN_RST 8'h00
`define RIE_FLAG_RST 8'h00
`define RIE_MODE_RST 2'h0

// mode field codes
`define RIE_MODE_COUNT32 2'h0
`define RIE_MODE_COUNT16 2'h1
`define RIE_MODE_CALENDAR 2'h2

// bits that exist in each mode
`define RIE_VALID_COUNT32 8'hC1
`define RIE_VALID_COUNT16 8'hC3
`define RIE_VALID_CALENDAR 8'hC1
`define RIE_VALID_RSVD 8'hC0

// bus codes
`define RIE_HSIZE_WORD 3'h2
`define RIE_HRESP_OKAY 1'h0

`endif

// File: rie_pkg.sv
/*
  Types shared by the interrupt-enable block.
  Assumes the constants header is compiled alongside.
*/
package rie_pkg;

  // one byte of enables or flags
  typedef logic [7:0] rie_bits_t;

  // register index taken from the word address
  typedef logic [5:0] rie_idx_t;

endpackage : rie_pkg

// File: rie_top.sv
/*
  Interrupt-enable logic of the real-time counter: shared enable state
  behind a clear view and a set view, the interrupt flags, the counting
  mode selector and the request to the processor, all over an AHB-Lite
  slave port.
  Assumes event inputs come from logic on the same clock, one-cycle
  pulses, and a single AHB-Lite master doing whole-word transfers.
*/
`timescale 1ns/100ps
`include "rie_regs.svh"

module rie_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // counter events
  input wire logic ovf_evt,
  input wire logic [1:0] cmp_evt,
  input wire logic sync_busy,
  input wire logic sync_busy_ctrl,
  // to the counter and the processor
  output logic [1:0] count_mode,
  output logic irq
);

  // bits that exist in a given mode
  function automatic rie_pkg::rie_bits_t valid_of(input logic [1:0] m);
    rie_pkg::rie_bits_t v;
    case (m)
      `RIE_MODE_COUNT32: v = `RIE_VALID_COUNT32;
      `RIE_MODE_COUNT16: v = `RIE_VALID_COUNT16;
      `RIE_MODE_CALENDAR: v = `RIE_VALID_CALENDAR;
      default: v = `RIE_VALID_RSVD;
    endcase
    return v;
  endfunction : valid_of

  // state
  logic wr_pend;
  rie_pkg::rie_idx_t wr_idx;
  rie_pkg::rie_bits_t enable;
  rie_pkg::rie_bits_t flags;
  logic busy_q;
  logic busy_ctrl_q;

  // next values
  logic next_wr_pend;
  rie_pkg::rie_idx_t next_wr_idx;
  rie_pkg::rie_bits_t next_enable;
  rie_pkg::rie_bits_t next_flags;
  logic [1:0] next_count_mode;
  logic [31:0] next_hrdata;
  logic next_irq;

  // helpers
  logic take;
  logic addr_ok;
  rie_pkg::rie_idx_t addr_idx;
  rie_pkg::rie_bits_t cur_valid;
  rie_pkg::rie_bits_t new_valid;
  rie_pkg::rie_bits_t wr_byte;
  rie_pkg::rie_bits_t en_clr;
  rie_pkg::rie_bits_t en_set;
  rie_pkg::rie_bits_t flag_clr;
  rie_pkg::rie_bits_t flag_set;
  logic sync_fall;

  // address phase decode; only aligned whole words in the low page map
  assign take = hsel & hready & htrans[1];
  assign addr_ok = (hsize == `RIE_HSIZE_WORD) && (haddr[1:0] == 2'h0)
                   && (haddr[31:8] == 24'h000000);
  assign addr_idx = haddr[7:2];
  assign wr_byte = hwdata[7:0];
  assign cur_valid = valid_of(count_mode);

  // bus phase tracking: write data arrives one cycle after its address
  always_comb begin
    next_wr_pend = take & hwrite & addr_ok;
    next_wr_idx = addr_idx;
  end

  // write strobes of the two views; zeros leave enables alone
  always_comb begin
    en_clr = 8'h00;
    en_set = 8'h00;
    if (wr_pend && wr_idx == `RIE_IDX_ENCLR) begin
      en_clr = wr_byte & cur_valid;
    end
    if (wr_pend && wr_idx == `RIE_IDX_ENSET) begin
      en_set = wr_byte & cur_valid;
    end
    // one state behind both views
    next_enable = (enable | en_set) & ~en_clr;
  end

  // mode selector, own register
  always_comb begin
    next_count_mode = count_mode;
    if (wr_pend && wr_idx == `RIE_IDX_MODE) begin
      next_count_mode = hwdata[1:0];
    end
    new_valid = valid_of(next_count_mode);
  end

  // sync-ready: fall of busy, not one that closes an enable or reset
  assign sync_fall = busy_q & ~sync_busy & ~busy_ctrl_q;

  // flags: a set in the clearing cycle wins, so no event is lost
  always_comb begin
    flag_set = 8'h00;
    flag_set[`RIE_BIT_OVF] = ovf_evt;
    flag_set[`RIE_BIT_SYNC] = sync_fall;
    flag_set[`RIE_BIT_COMPARE1_SOURCE] = cmp_evt[1];
    flag_set[`RIE_BIT_COMPARE0_SOURCE] = cmp_evt[0];
    flag_set = flag_set & cur_valid;
    flag_clr = 8'h00;
    if (wr_pend && wr_idx == `RIE_IDX_FLAGS) begin
      flag_clr = wr_byte;
    end
    next_flags = (flags & ~flag_clr) | flag_set;
  end

  // request from the values the registers are about to hold
  always_comb begin
    next_irq = |(next_flags & next_enable & new_valid);
  end

  // read data taken from next values, so a write just ahead is seen
  always_comb begin
    next_hrdata = 32'h00000000;
    if (take && !hwrite && addr_ok) begin
      case (addr_idx)
        `RIE_IDX_ENCLR: next_hrdata = {24'h000000, next_enable & new_valid};
        `RIE_IDX_ENSET: next_hrdata = {24'h000000, next_enable & new_valid};
        `RIE_IDX_FLAGS: next_hrdata = {24'h000000, next_flags & new_valid};
        `RIE_IDX_MODE: next_hrdata = {30'h00000000, next_count_mode};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
      enable <= `RIE_EN_RST;
      flags <= `RIE_FLAG_RST;
      count_mode <= `RIE_MODE_RST;
      busy_q <= 1'b0;
      busy_ctrl_q <= 1'b0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= `RIE_HRESP_OKAY;
      irq <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      enable <= next_enable;
      flags <= next_flags;
      count_mode <= next_count_mode;
      busy_q <= sync_busy;
      busy_ctrl_q <= sync_busy_ctrl;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1; // zero wait states, never stalls
      hresp <= `RIE_HRESP_OKAY;
      irq <= next_irq;
    end
  end

endmodule : rie_top

// File: rie_evt_src.sv
/* Event source standing in for the counter core beside the block.
   Assumes the bench kicks it on clk; a busy pulse always ends in a fall. */
`timescale 1ns/100ps
module rie_evt_src (
  // clock and kicks from the bench
  input wire logic clk,
  input wire logic [3:0] kick,
  input wire logic ctl,
  // events to the block
  output logic ovf_evt,
  output logic [1:0] cmp_evt,
  output logic sync_busy,
  output logic sync_busy_ctrl
);
  // one-cycle pulses from kick, ctl followed as a level; registered so they never move on the sampling edge
  always_ff @(posedge clk) begin
    ovf_evt <= kick[0];
    cmp_evt <= kick[2:1];
    sync_busy <= kick[3];
    sync_busy_ctrl <= ctl;
  end
endmodule : rie_evt_src

// File: rie_properties.sv
/* Port checker of rie_top, bound at the foot of this file.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module rie_properties (
  // clock, reset and bus
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // events and outputs
  input wire logic ovf_evt,
  input wire logic [1:0] cmp_evt,
  input wire logic sync_busy,
  input wire logic sync_busy_ctrl,
  input wire logic [1:0] count_mode,
  input wire logic irq
);
  logic wr_dp;
  logic rd_dp;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // data-phase trackers, gated so a reset leaves them clear
  always_ff @(posedge clk) begin
    wr_dp <= rst_n && hsel && hready && htrans[1] && hwrite;
    rd_dp <= rst_n && hsel && hready && htrans[1] && !hwrite;
  end
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready");
  property p_idle; !rd_dp |-> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_rsvd; rd_dp |-> hrdata[31:8] == 24'h0 && hrdata[5:2] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_bit1; rd_dp && count_mode == 2'h0 |-> !hrdata[1]; endproperty
  a_bit1: assert property (p_bit1) else $error("bit 1 set in mode 0");
  property p_mode; !wr_dp |=> $stable(count_mode); endproperty
  a_mode: assert property (p_mode) else $error("mode moved alone");
  property p_fell; $fell(irq) |-> $past(wr_dp); endproperty
  a_fell: assert property (p_fell) else $error("irq fell alone");
  property p_rose;
    $rose(irq) |-> $past(wr_dp) || $past(ovf_evt) || $past(cmp_evt) != 2'h0
      || $past(sync_busy, 2);
  endproperty
  a_rose: assert property (p_rose) else $error("irq rose alone");
  property p_sync;
    $rose(irq) && !$past(wr_dp) && !$past(ovf_evt) && $past(cmp_evt) == 2'h0
      |-> $past(sync_busy, 2) && !$past(sync_busy) && !$past(sync_busy_ctrl, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("bad sync request");
  c_irq: cover property ($rose(irq));
  c_sync: cover property (sync_busy ##1 !sync_busy);
  c_mode16: cover property (rd_dp && count_mode == 2'h1);
endmodule : rie_properties
bind rie_top rie_properties chk_u (.*);

// File: rie_top_test.sv
/* Random bench of rie_top with the event source model.
   Assumes the checker binds itself; all expectations come from a model here. */
`timescale 1ns/100ps
module rie_top_test;
  logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, ctl = 1'b0, hrdy, irq, ovf, busy, bctl;
  logic [1:0] htrans = 2'h0, cmp;
  logic [3:0] kick = 4'h0;
  logic [7:0] haddr = 8'h0, en, fl, v;
  logic [31:0] hwdata = 32'h0, hrdata, rd, r = 32'hA378;
  int n_errors = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  rie_top dut_u (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr({24'h0, haddr}),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(), .hrdata(hrdata), .ovf_evt(ovf), .cmp_evt(cmp),
    .sync_busy(busy), .sync_busy_ctrl(bctl), .count_mode(), .irq(irq));
  rie_evt_src src_u (.clk(clk), .kick(kick), .ctl(ctl), .ovf_evt(ovf), .cmp_evt(cmp),
    .sync_busy(busy), .sync_busy_ctrl(bctl));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // bits that exist per mode; mode 3 keeps only the shared two
  function automatic logic [7:0] vmask(input logic [1:0] m);
    return m == 2'h1 ? 8'hC3 : (m == 2'h3 ? 8'hC0 : 8'hC1);
  endfunction : vmask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one word transfer; no cycle count assumed, waits on hready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and the unmapped words between
    for (int i = 6; i < 17; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0);
      chk("reset", rd, 32'h0);
    end
    en = 8'h0;
    fl = 8'h0;
    for (int m = 0; m < 4; m++) begin
      ahb(1'b1, 8'h30, 32'(m));
      v = vmask(2'(m));
      repeat (12) begin
        r = lfsr(r);
        ahb(1'b1, r[8] ? 8'h1C : 8'h18, {24'h0, r[7:0]});
        en = r[8] ? en | (r[7:0] & v) : en & ~(r[7:0] & v);
        ahb(1'b0, r[9] ? 8'h1C : 8'h18, 32'h0);
        chk("enable", rd, {24'h0, en & v});
        kick <= r[15:12];
        ctl <= r[16];
        @(posedge clk);
        kick <= 4'h0;
        repeat (6) @(posedge clk);
        fl = fl | ({r[12], r[15] & ~r[16], 4'h0, r[14], r[13]} & v);
        chk("irq", 32'(irq), 32'(|(fl & en & v)));
        ahb(1'b1, 8'h20, {24'h0, r[31:24]});
        fl = fl & ~(r[31:24] & v);
        ahb(1'b0, 8'h20, 32'h0);
        chk("flags", rd, {24'h0, fl});
        ahb(1'b1, 8'h20, 32'hFF);
        fl = 8'h0;
      end
    end
    tally_and_finish();
  end
  // cut a hang short; the run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
endmodule : rie_top_test
